// ### dma_req_pkg.sv
package dma_req_pkg;

    // Data path and memory widths
    localparam int ADDR_W          = 32;
    localparam int DATA_W          = 32;
    localparam int LEN_W           = 16;
    localparam int BURST_W         = 4;
    localparam int NUM_PERIPH_IRQ  = 16;
    localparam int NUM_DMA_CH      = 2;
    localparam int NUM_IRQ_SRC     = NUM_PERIPH_IRQ + NUM_DMA_CH;

    // Temporary buffer depth in words
    localparam int BUF_DEPTH       = 16;
    localparam int BUF_AW          = 4;

    // Descriptor layout: four words, next descriptor at this stride
    localparam logic [ADDR_W-1:0] DESC_STRIDE   = 32'h0000_0010;
    localparam logic [1:0]        DESC_WORD_SRC = 2'h0;
    localparam logic [1:0]        DESC_WORD_LEN = 2'h1;
    localparam logic [1:0]        DESC_WORD_DST = 2'h2;
    localparam logic [1:0]        DESC_WORD_CTL = 2'h3;
    localparam logic [1:0]        DESC_LAST_WORD = 2'h3;
    localparam int                CTL_BIT_WRAP  = 15;
    localparam int                CTL_BIT_IRQ   = 14;
    localparam int                CTL_BIT_LAST  = 13;
    localparam int                CTL_BIT_FULL  = 12;

    // Byte units per word transfer
    localparam logic [LEN_W-1:0] BYTES_PER_WORD = 16'h0004;

    // Peripheral data widths and bus accesses per word
    localparam logic [1:0] WIDTH_8   = 2'h0;
    localparam logic [1:0] WIDTH_16  = 2'h1;
    localparam logic [1:0] WIDTH_32  = 2'h2;
    localparam logic [2:0] ACC_8     = 3'h4;
    localparam logic [2:0] ACC_16    = 3'h2;
    localparam logic [2:0] ACC_32    = 3'h1;

    // Request pulse window, in clock cycles
    localparam int         REQ_MIN_CYC = 4;
    localparam int         REQ_MAX_CYC = 20;
    localparam logic [4:0] REQ_DETECT  = 5'(REQ_MIN_CYC - 2);

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_FETCH     = 4'b0001,
        ST_CHECK     = 4'b0010,
        ST_READ      = 4'b0011,
        ST_WRITE     = 4'b0100,
        ST_RETIRE    = 4'b0101,
        ST_IRQ       = 4'b0110
    } dma_state_t;

endpackage : dma_req_pkg

// ### ext_req_dma.sv
`timescale 1ns/1ps
`default_nettype none

module ext_req_dma
    import dma_req_pkg::*;
(
    // Clocking
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire logic                        clk_en,
    // Peripheral request and software control
    input  wire logic                        periph_req,
    input  wire logic                        channel_go,
    input  wire logic                        mem_to_mem,
    input  wire logic                        complete_irq_en,
    input  wire logic                        full_expected,
    input  wire logic [dma_req_pkg::ADDR_W-1:0] desc_base,
    input  wire logic [1:0]                  memory_width,
    // Shared memory port, lower priority than peripheral-bus masters
    input  wire logic                        periph_bus_busy,
    output logic                             mem_req,
    output logic                             mem_we,
    output logic [dma_req_pkg::ADDR_W-1:0]   mem_addr,
    output logic [dma_req_pkg::DATA_W-1:0]   mem_wdata,
    input  wire logic                        mem_ack,
    input  wire logic [dma_req_pkg::DATA_W-1:0] mem_rdata,
    // Channel status
    output logic                             busy,
    output logic                             not_ready_flag,
    output logic                             done_pulse,
    output logic                             chan_irq,
    output logic [2:0]                       accesses_per_word,
    // Interrupt aggregation
    input  wire logic [dma_req_pkg::NUM_IRQ_SRC-1:0] irq_src,
    input  wire logic [dma_req_pkg::NUM_IRQ_SRC-1:0] irq_enable,
    output logic [dma_req_pkg::NUM_IRQ_SRC-1:0]      irq_status,
    output logic                             aggregate_irq
);
    import dma_req_pkg::*;

    dma_state_t          state_reg;
    dma_state_t          state_next;
    logic                req_pulse;
    logic                start;
    logic [ADDR_W-1:0]   desc_ptr_reg;
    logic [ADDR_W-1:0]   src_reg;
    logic [ADDR_W-1:0]   dst_reg;
    logic [LEN_W-1:0]    len_reg;
    logic [DATA_W-1:0]   ctl_reg;
    logic [1:0]          dword_reg;
    logic [BUF_AW-1:0]   idx_reg;
    logic [LEN_W-1:0]    bytes_reg;
    logic [DATA_W-1:0]   tmp_buf [BUF_DEPTH];
    logic                go_pulse_reg;
    logic                go_seen;
    logic                grant;
    logic                last_bytes;

    req_sync i_req_sync (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .clk_en    (clk_en),
        .req_async (periph_req),
        .req_pulse (req_pulse)
    );

    // Edge of the software go strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            go_pulse_reg <= 1'b0;
        end else if (clk_en) begin
            go_pulse_reg <= channel_go;
        end
    end
    assign go_seen = channel_go && !go_pulse_reg;

    // Memory-to-memory mode starts only from go, never from the pin
    assign start = mem_to_mem ? go_seen : req_pulse;

    // Peripheral-bus masters own the shared slot whenever they ask
    assign grant = mem_ack && !periph_bus_busy;
    assign last_bytes = (bytes_reg + BYTES_PER_WORD) >= len_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (start) begin
                    state_next = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (grant && dword_reg == DESC_LAST_WORD) begin
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (ctl_reg[CTL_BIT_FULL] != full_expected) begin
                    state_next = ST_IDLE;
                end else if (len_reg == '0) begin
                    state_next = ST_RETIRE;
                end else begin
                    state_next = ST_READ;
                end
            end
            ST_READ: begin
                if (grant && last_bytes) begin
                    state_next = ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (grant && last_bytes) begin
                    state_next = ST_RETIRE;
                end
            end
            ST_RETIRE: begin
                if (grant) begin
                    state_next = ST_IRQ;
                end
            end
            ST_IRQ: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= ST_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // Descriptor fetch, pointer walk and byte counting
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            desc_ptr_reg <= '0;
            src_reg      <= '0;
            dst_reg      <= '0;
            len_reg      <= '0;
            ctl_reg      <= '0;
            dword_reg    <= 2'h0;
            idx_reg      <= '0;
            bytes_reg    <= '0;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    dword_reg <= 2'h0;
                    idx_reg   <= '0;
                    bytes_reg <= '0;
                    if (desc_ptr_reg == '0) begin
                        desc_ptr_reg <= desc_base;
                    end
                end
                ST_FETCH: begin
                    if (grant) begin
                        dword_reg <= dword_reg + 2'h1;
                        case (dword_reg)
                            DESC_WORD_SRC: src_reg <= mem_rdata;
                            DESC_WORD_LEN: len_reg <= mem_rdata[LEN_W-1:0];
                            DESC_WORD_DST: dst_reg <= mem_rdata;
                            default:       ctl_reg <= mem_rdata;
                        endcase
                    end
                end
                ST_READ, ST_WRITE: begin
                    if (grant) begin
                        // Whole words only; a short tail still moves a full word
                        idx_reg   <= last_bytes ? '0 : idx_reg + 1'b1;
                        bytes_reg <= last_bytes ? '0 : bytes_reg + BYTES_PER_WORD;
                    end
                end
                ST_RETIRE: begin
                    if (grant) begin
                        desc_ptr_reg <= ctl_reg[CTL_BIT_WRAP] ? desc_base
                                                              : desc_ptr_reg + DESC_STRIDE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // On-chip temporary buffer
    always_ff @(posedge clk_sys) begin
        if (clk_en && state_reg == ST_READ && grant) begin
            tmp_buf[idx_reg] <= mem_rdata;
        end
    end

    // Memory request outputs, registered from the current state and grant
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= '0;
            mem_wdata <= '0;
        end else if (clk_en) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
            case (state_reg)
                ST_FETCH: begin
                    mem_req  <= !(grant && dword_reg == DESC_LAST_WORD);
                    mem_addr <= desc_ptr_reg + {28'h000_0000, grant ? dword_reg + 2'h1
                                                                    : dword_reg, 2'h0};
                end
                ST_READ: begin
                    mem_req  <= !(grant && last_bytes);
                    mem_addr <= src_reg + {16'h0000, grant ? bytes_reg + BYTES_PER_WORD
                                                           : bytes_reg};
                end
                ST_WRITE: begin
                    // Data goes to the target address, not back to the source
                    mem_req   <= !(grant && last_bytes);
                    mem_we    <= 1'b1;
                    mem_addr  <= dst_reg + {16'h0000, grant ? bytes_reg + BYTES_PER_WORD : bytes_reg};
                    mem_wdata <= tmp_buf[grant ? idx_reg + 1'b1 : idx_reg];
                end
                ST_RETIRE: begin
                    // Descriptor written back with the full bit flipped
                    mem_req   <= !grant;
                    mem_we    <= !grant;
                    mem_addr  <= desc_ptr_reg + {28'h000_0000, DESC_WORD_CTL, 2'h0};
                    mem_wdata <= ctl_reg ^ (DATA_W'(1) << CTL_BIT_FULL);
                end
                default: begin
                end
            endcase
            if (state_reg == ST_IDLE && start) begin
                mem_req  <= 1'b1;
                mem_addr <= desc_ptr_reg == '0 ? desc_base : desc_ptr_reg;
            end
        end
    end

    // Channel status outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            busy              <= 1'b0;
            not_ready_flag    <= 1'b0;
            done_pulse        <= 1'b0;
            chan_irq          <= 1'b0;
            accesses_per_word <= ACC_32;
        end else if (clk_en) begin
            busy       <= (state_next != ST_IDLE);
            done_pulse <= (state_reg == ST_IRQ);
            // Completion interrupt forced by descriptor bit
            chan_irq   <= (state_reg == ST_IRQ) &&
                          (complete_irq_en || ctl_reg[CTL_BIT_IRQ]);
            if (state_reg == ST_CHECK && ctl_reg[CTL_BIT_FULL] != full_expected) begin
                not_ready_flag <= 1'b1;
            end else if (start) begin
                not_ready_flag <= 1'b0;
            end
            case (memory_width)
                WIDTH_8:  accesses_per_word <= ACC_8;
                WIDTH_16: accesses_per_word <= ACC_16;
                default:  accesses_per_word <= ACC_32;
            endcase
        end
    end

    // Interrupt aggregation: status mirrors sources, cleared only at source
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_status    <= '0;
            aggregate_irq <= 1'b0;
        end else if (clk_en) begin
            irq_status    <= irq_src;
            aggregate_irq <= |(irq_src & irq_enable);
        end
    end

endmodule : ext_req_dma
`default_nettype wire

// ### ext_req_dma_props.sv
`timescale 1ns/1ps
`default_nettype none

module ext_req_dma_chk
    import dma_req_pkg::*;
(
    // Clocking
    input wire logic                                 clk_sys,
    input wire logic                                 reset,
    // Request and control
    input wire logic                                 periph_req,
    input wire logic                                 mem_to_mem,
    input wire logic [1:0]                           memory_width,
    // Memory port
    input wire logic                                 periph_bus_busy,
    input wire logic                                 mem_req,
    input wire logic                                 mem_we,
    input wire logic [dma_req_pkg::ADDR_W-1:0]       mem_addr,
    input wire logic                                 mem_ack,
    // Status and interrupts
    input wire logic                                 busy,
    input wire logic                                 done_pulse,
    input wire logic                                 chan_irq,
    input wire logic [2:0]                           accesses_per_word,
    input wire logic [dma_req_pkg::NUM_IRQ_SRC-1:0]  irq_src,
    input wire logic [dma_req_pkg::NUM_IRQ_SRC-1:0]  irq_enable,
    input wire logic [dma_req_pkg::NUM_IRQ_SRC-1:0]  irq_status,
    input wire logic                                 aggregate_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence req_seen;
        $rose(periph_req) && !busy && !mem_to_mem ##1 periph_req [*3];
    endsequence
    sequence beat_open;
        mem_req && !(mem_ack && !periph_bus_busy);
    endsequence

    AST_START: assert property (req_seen |-> ##[0:6] busy)
        else $error("request held four cycles not taken");
    AST_HOLD: assert property (beat_open |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("beat changed before acceptance");
    AST_DONE_ONE: assert property (done_pulse |=> !done_pulse)
        else $error("completion pulse too long");
    AST_DONE_IDLE: assert property (done_pulse |-> ##[0:2] !busy)
        else $error("channel not idle after completion");
    AST_IRQ_DONE: assert property (chan_irq |-> done_pulse)
        else $error("channel interrupt outside completion");
    AST_MEM_BUSY: assert property (mem_req |-> busy)
        else $error("memory request while idle");
    AST_APW: assert property ($stable(memory_width) |=> accesses_per_word ==
        ($past(memory_width) == WIDTH_8 ? ACC_8 :
         $past(memory_width) == WIDTH_16 ? ACC_16 : ACC_32))
        else $error("accesses per word wrong");
    AST_STATUS: assert property (!$past(reset) |-> irq_status == $past(irq_src))
        else $error("interrupt status mismatch");
    AST_AGG: assert property (!$past(reset) |->
        aggregate_irq == |($past(irq_src) & $past(irq_enable)))
        else $error("aggregate interrupt mismatch");
endmodule : ext_req_dma_chk

bind ext_req_dma ext_req_dma_chk i_ext_req_dma_chk (.clk_sys, .reset, .periph_req, .mem_to_mem,
    .memory_width, .periph_bus_busy, .mem_req, .mem_we, .mem_addr, .mem_ack, .busy, .done_pulse,
    .chan_irq, .accesses_per_word, .irq_src, .irq_enable, .irq_status, .aggregate_irq);

`default_nettype wire

// ### mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module mem_model
    import dma_req_pkg::*;
(
    // Clocking and pacing
    input wire logic                            clk_sys,
    input wire logic                            reset,
    input wire logic                            slow,
    input wire logic                            periph_bus_busy,
    // Memory port
    input wire logic                            mem_req,
    input wire logic                            mem_we,
    input wire logic [dma_req_pkg::ADDR_W-1:0]  mem_addr,
    input wire logic [dma_req_pkg::DATA_W-1:0]  mem_wdata,
    output logic                                mem_ack,
    output logic [dma_req_pkg::DATA_W-1:0]      mem_rdata
);
    logic [DATA_W-1:0] words [0:63];
    logic [1:0]        pace_reg;
    logic [5:0]        idx;

    // Slow mode: rounded-up read wait, in clock cycles
    localparam logic [1:0] READ_WAIT_COUNT = 2'h3;

    assign idx = mem_addr[7:2];
    // Inverted outside ack so stale data never looks valid
    assign mem_rdata = mem_ack ? words[idx] : ~words[idx];

    always_ff @(posedge clk_sys) begin
        pace_reg <= reset ? 2'h0 : pace_reg + 2'h1;
        if (reset) begin
            mem_ack <= 1'b0;
        end else if (mem_ack && !periph_bus_busy) begin
            // Ack holds while the peripheral bus owns the slot
            mem_ack <= 1'b0;
        end else if (mem_req && (!slow || pace_reg == READ_WAIT_COUNT)) begin
            // Back-to-back beats; chip select need not toggle
            mem_ack <= 1'b1;
        end
    end

    // Plain process: the bench also preloads and patches these words
    always @(posedge clk_sys) begin
        if (!reset && mem_ack && !periph_bus_busy && mem_we) begin
            words[idx] <= mem_wdata;
        end
    end
endmodule : mem_model

`default_nettype wire

// ### req_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser plus a rising-edge qualifier for the request line
module req_sync
    import dma_req_pkg::*;
(
    // Clocking
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic clk_en,
    // Asynchronous request in, qualified pulse out
    input  wire logic req_async,
    output logic      req_pulse
);

    logic       meta_reg;
    logic       sync_reg;
    logic [4:0] hold_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else if (clk_en) begin
            meta_reg <= req_async;
            sync_reg <= meta_reg;
        end
    end

    // Count high cycles; one pulse once the line has been seen long enough
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hold_reg  <= 5'h00;
            req_pulse <= 1'b0;
        end else if (clk_en) begin
            req_pulse <= sync_reg && (hold_reg == REQ_DETECT);
            if (!sync_reg) begin
                hold_reg <= 5'h00;
            end else if (hold_reg != 5'h1F) begin
                hold_reg <= hold_reg + 5'h01;
            end
        end
    end

endmodule : req_sync
`default_nettype wire

// ### test_ext_req_dma.sv
`timescale 1ns/1ps
`default_nettype none

module test_ext_req_dma;
    import dma_req_pkg::*;
    logic clk_sys, reset, clk_en, periph_req, channel_go, mem_to_mem, complete_irq_en;
    logic full_expected, periph_bus_busy, mem_req, mem_we, mem_ack, slow, busy;
    logic not_ready_flag, done_pulse, chan_irq, aggregate_irq;
    logic [1:0]             memory_width;
    logic [2:0]             accesses_per_word;
    logic [ADDR_W-1:0]      desc_base, mem_addr;
    logic [DATA_W-1:0]      mem_wdata, mem_rdata;
    logic [NUM_IRQ_SRC-1:0] irq_src, irq_enable, irq_status;
    int n_errors;
    int check_count;

    ext_req_dma i_ext_req_dma (.clk_sys, .reset, .clk_en, .periph_req, .channel_go,
        .mem_to_mem, .complete_irq_en, .full_expected, .desc_base, .memory_width,
        .periph_bus_busy, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
        .busy, .not_ready_flag, .done_pulse, .chan_irq, .accesses_per_word, .irq_src,
        .irq_enable, .irq_status, .aggregate_irq);
    mem_model i_mem_model (.clk_sys, .reset, .slow, .periph_bus_busy, .mem_req, .mem_we,
        .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk_vec(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk_vec

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : tick

    task automatic pulse_req(input int n);
        @(posedge clk_sys);
        periph_req <= 1'b1;
        tick(n);
        periph_req <= 1'b0;
    endtask : pulse_req

    task automatic wait_done(output logic irq);
        int i;
        irq = 1'b0;
        for (i = 0; i < 300; i++) begin
            @(negedge clk_sys);
            if (done_pulse === 1'b1) begin
                irq = chan_irq;
                break;
            end
        end
        if (i == 300) begin
            n_errors++;
            $display("[ERR] %0t no completion seen", $time);
        end
    endtask : wait_done

    task automatic close_out;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        logic irq;
        {periph_req, channel_go, mem_to_mem, complete_irq_en, periph_bus_busy, slow} = '0;
        {reset, clk_en, full_expected} = 3'b111;
        desc_base = 32'h0000_0000;
        memory_width = WIDTH_8;
        irq_src = '0;
        irq_enable = '0;
        n_errors = 0;
        check_count = 0;
        // Whole-word lengths; descriptor 0 asks for an interrupt, descriptor 1 not yet full
        i_mem_model.words = '{0: 32'h0000_0040, 1: 32'h0000_0008, 2: 32'h0000_0080,
            3: 32'h0000_5000, 4: 32'h0000_0048, 5: 32'h0000_0004, 6: 32'h0000_0088,
            16: 32'hA5A5_0001, 17: 32'hA5A5_0002, 18: 32'hA5A5_0003,
            default: 32'h0000_0000};
        tick(6);
        reset <= 1'b0;
        @(negedge clk_sys);
        chk_bit(busy, 1'b0);
        chk_vec(32'(accesses_per_word), 32'h0000_0001);
        for (int w = 2; w >= 0; w--) begin
            @(posedge clk_sys);
            memory_width <= 2'(w);
            tick(2);
            @(negedge clk_sys);
            chk_vec(32'(accesses_per_word), 32'h0000_0004 >> w);
        end
        // Slow memory, peripheral bus holding the slot from the first descriptor fetch beat
        slow = 1'b1;
        pulse_req(6);
        periph_bus_busy <= 1'b1;
        tick(10);
        periph_bus_busy <= 1'b0;
        wait_done(irq);
        chk_bit(irq, 1'b1);
        chk_vec(i_mem_model.words[32], 32'hA5A5_0001);
        chk_vec(i_mem_model.words[33], 32'hA5A5_0002);
        chk_vec(i_mem_model.words[3], 32'h0000_4000);
        chk_bit(not_ready_flag, 1'b0);
        slow = 1'b0;
        pulse_req(20);
        tick(20);
        @(negedge clk_sys);
        chk_bit(not_ready_flag, 1'b1);
        chk_vec(i_mem_model.words[34], 32'h0000_0000);
        chk_bit(busy, 1'b0);
        i_mem_model.words[7] = 32'h0000_1000;
        @(posedge clk_sys);
        complete_irq_en <= 1'b1;
        mem_to_mem <= 1'b1;
        pulse_req(6);
        tick(15);
        @(negedge clk_sys);
        chk_bit(busy, 1'b0);
        chk_bit(not_ready_flag, 1'b1);
        @(posedge clk_sys);
        channel_go <= 1'b1;
        @(posedge clk_sys);
        channel_go <= 1'b0;
        wait_done(irq);
        chk_bit(irq, 1'b1);
        chk_bit(not_ready_flag, 1'b0);
        chk_vec(i_mem_model.words[34], 32'hA5A5_0003);
        chk_vec(i_mem_model.words[7], 32'h0000_0000);
        @(posedge clk_sys);
        mem_to_mem <= 1'b0;
        for (int i = 0; i < NUM_IRQ_SRC; i++) begin
            @(posedge clk_sys);
            irq_src <= NUM_IRQ_SRC'(1) << i;
            irq_enable <= i[0] ? '1 : '0;
            tick(1);
            @(negedge clk_sys);
            chk_vec(32'(irq_status), 32'h0000_0001 << i);
            chk_bit(aggregate_irq, i[0]);
        end
        @(posedge clk_sys);
        irq_src <= '0;
        tick(1);
        @(negedge clk_sys);
        chk_bit(aggregate_irq, 1'b0);
        close_out();
    end

    initial begin
        #100us;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        close_out();
    end
endmodule : test_ext_req_dma

`default_nettype wire
